// ==== rtl/control_mode_pin_defines.svh ====
`ifndef CONTROL_MODE_PIN_DEFINES_SVH
`define CONTROL_MODE_PIN_DEFINES_SVH

// primary interface format codes, {ctrl_select_pin, serial clock pin}
`define FMT_RJ24        2'h0
`define FMT_RJ20        2'h1
`define FMT_LJ24        2'h2
`define FMT_I2S24       2'h3
// word lengths in bits
`define WLEN_24         6'h18
`define WLEN_20         6'h14
// spdif transmit source codes, {route_pin_four, route_pin_three}
`define SPDIF_TX_SOURCE_SEL_SPDIF     2'h0
`define SPDIF_TX_SOURCE_SEL_ADC       2'h1
`define SPDIF_TX_SOURCE_SEL_BAD       2'h2
`define SPDIF_TX_SOURCE_SEL_PRIMARY   2'h3
// default master rate: mclk = 256 fs, 64 bit clocks per frame
`define TX_RATE_MULT    10'h100
`define TX_BCLK_FRAME   8'h40
// number of strap inputs passed through the synchroniser
`define STRAP_COUNT     10

`endif

// ==== rtl/control_mode_pin_pkg.sv ====
package control_mode_pin_pkg;

	typedef enum logic [1:0] {
		FMT_RIGHT24,
		FMT_RIGHT20,
		FMT_LEFT24,
		FMT_I2S24
	} fmt_type;

	typedef struct packed {
		logic       dac_source_sel;
		logic       primary_tx_source_sel;
		logic [1:0] spdif_tx_source_sel;
	} route_type;

	typedef struct packed {
		fmt_type    fmt;
		logic [5:0] word_len;
		logic       tx_master;
		logic [9:0] primary_tx_rate;
		logic [7:0] bitclk_per_frame_sel;
	} port_cfg_type;

	typedef struct packed {
		logic       route_pin_one;
		logic       route_pin_two;
		logic       route_pin_three;
		logic       route_pin_four;
		logic       ctrl_select_pin;
		logic       ctrl_sclk_pin;
		logic       ctrl_serial_in_pin;
		logic       mute_pin;
		logic       mute_pin_float;
		logic       multifunc_pin_seven;
	} strap_type;

	typedef struct packed {
		logic       hw_mode;
		route_type  route;
		port_cfg_type cfg;
		logic       secondary_en;
		logic [3:0] dac_mute;
		logic       powerdown;
		logic       tx_src_err;
		logic       mode_seen;
	} state_type;

endpackage

// ==== rtl/strap_sync.sv ====
`timescale 1ns/10ps
`include "control_mode_pin_defines.svh"

// three-stage synchroniser; the output only moves when stages two and three agree
module strap_sync (
	input  wire logic                        i_clk,
	input  wire logic                        i_nrst,
	input  wire logic [`STRAP_COUNT-1:0]     i_async,
	output logic      [`STRAP_COUNT-1:0]     o_sync
);
	logic [`STRAP_COUNT-1:0] s1_r;
	logic [`STRAP_COUNT-1:0] s2_r;
	logic [`STRAP_COUNT-1:0] s3_r;
	logic [`STRAP_COUNT-1:0] q_r;

	genvar g;
	generate
		for (g = 0; g < `STRAP_COUNT; g++) begin : g_bit
			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					s1_r[g] <= 1'b0;
					s2_r[g] <= 1'b0;
					s3_r[g] <= 1'b0;
					q_r[g]  <= 1'b0;
				end else begin
					s1_r[g] <= i_async[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g]) begin
						q_r[g] <= s3_r[g];
					end
				end
			end
		end
	endgenerate

	assign o_sync = q_r;
endmodule

// ==== rtl/hw_mode_pin_config.sv ====
`timescale 1ns/10ps
`include "control_mode_pin_defines.svh"

module hw_mode_pin_config (
	input  wire logic                   I_CORE_CLK,
	input  wire logic                   I_NRST,
	input  wire logic                   i_control_mode_pin,
	input  wire logic                   i_route_pin_one,
	input  wire logic                   i_route_pin_two,
	input  wire logic                   i_route_pin_three,
	input  wire logic                   i_route_pin_four,
	input  wire logic                   i_ctrl_select_pin,
	input  wire logic                   i_ctrl_sclk_pin,
	input  wire logic                   i_ctrl_serial_in_pin,
	input  wire logic                   i_mute_pin,
	input  wire logic                   i_mute_pin_float,
	input  wire logic                   i_multifunc_pin_seven,
	input  wire control_mode_pin_pkg::route_type  i_sw_route,
	input  wire control_mode_pin_pkg::port_cfg_type i_sw_cfg,
	input  wire logic [1:0]             i_zero_mute_select,
	input  wire logic                   i_mute_pin_disable,
	input  wire logic                   i_sw_powerdown,
	input  wire logic                   i_sw_wire_mode_out,
	input  wire logic                   i_sw_serial_out,
	input  wire logic                   i_sw_serial_out_oe,
	input  wire logic                   i_secondary_frame_clock,
	input  wire logic                   i_secondary_frame_clock_oe,
	input  wire logic                   i_gp_output_seven,
	input  wire logic                   i_gp_output_seven_sel,
	input  wire logic                   i_rx_unlock,
	input  wire logic                   i_non_audio_code,
	input  wire logic                   i_cs_bit_one,
	input  wire logic                   i_all_dac_zero_flag,
	output logic                        o_hw_mode,
	output control_mode_pin_pkg::route_type       o_route,
	output control_mode_pin_pkg::port_cfg_type    o_rx_cfg,
	output control_mode_pin_pkg::port_cfg_type    o_tx_cfg,
	output logic                        o_secondary_en,
	output logic [3:0]                  o_dac_soft_mute,
	output logic                        o_powerdown,
	output logic                        o_tx_src_err,
	output logic                        o_wire_mode_pin_o,
	output logic                        o_wire_mode_pin_oe,
	output logic                        o_ctrl_serial_out_pin_o,
	output logic                        o_ctrl_serial_out_pin_oe,
	output logic                        o_mute_pin_o,
	output logic                        o_mute_pin_oe,
	output logic                        o_multifunc_pin_seven_o,
	output logic                        o_multifunc_pin_seven_oe
);
	control_mode_pin_pkg::state_type  st_r;
	control_mode_pin_pkg::state_type  st_nxt;
	control_mode_pin_pkg::strap_type  strap;
	logic [`STRAP_COUNT:0]  sync_in;
	logic [`STRAP_COUNT:0]  sync_out;
	logic                   hw;
	logic                   zero_r;
	logic                   unlock_r;
	logic                   non_audio_r;
	logic [`STRAP_COUNT-1:0] mode_bus;

	// decode used for both directions of the primary port
	function automatic logic [5:0] fmt_len(input control_mode_pin_pkg::fmt_type f);
		fmt_len = (f == control_mode_pin_pkg::FMT_RIGHT20) ? `WLEN_20 : `WLEN_24;
	endfunction

	assign sync_in = {i_control_mode_pin, i_route_pin_one, i_route_pin_two,
		i_route_pin_three, i_route_pin_four, i_ctrl_select_pin, i_ctrl_sclk_pin,
		i_ctrl_serial_in_pin, i_mute_pin, i_mute_pin_float, i_multifunc_pin_seven};

	// mode pin gets its own synchroniser so the strap group keeps the packed struct width
	strap_sync u_sync_lo (
		.i_clk   (I_CORE_CLK),
		.i_nrst  (I_NRST),
		.i_async (sync_in[`STRAP_COUNT-1:0]),
		.o_sync  (sync_out[`STRAP_COUNT-1:0])
	);

	strap_sync u_sync_mode (
		.i_clk   (I_CORE_CLK),
		.i_nrst  (I_NRST),
		.i_async ({{(`STRAP_COUNT-1){1'b0}}, sync_in[`STRAP_COUNT]}),
		.o_sync  (mode_bus)
	);

	assign sync_out[`STRAP_COUNT] = mode_bus[0];
	assign strap = control_mode_pin_pkg::strap_type'(sync_out[`STRAP_COUNT-1:0]);
	assign hw    = sync_out[`STRAP_COUNT];

	always_comb begin
		st_nxt = st_r;
		st_nxt.hw_mode   = hw;
		st_nxt.mode_seen = 1'b1;
		if (hw) begin
			st_nxt.route.dac_source_sel        = strap.route_pin_one;
			st_nxt.route.primary_tx_source_sel = strap.route_pin_two;
			// unsupported code keeps the last legal source rather than glitching
			if ({strap.route_pin_four, strap.route_pin_three} != `SPDIF_TX_SOURCE_SEL_BAD) begin
				st_nxt.route.spdif_tx_source_sel =
					{strap.route_pin_four, strap.route_pin_three};
			end
			st_nxt.tx_src_err = ({strap.route_pin_four, strap.route_pin_three}
				== `SPDIF_TX_SOURCE_SEL_BAD);
			st_nxt.cfg.fmt = control_mode_pin_pkg::fmt_type'({strap.ctrl_select_pin,
				strap.ctrl_sclk_pin});
			st_nxt.cfg.word_len  = fmt_len(st_nxt.cfg.fmt);
			st_nxt.cfg.tx_master = strap.ctrl_serial_in_pin;
			st_nxt.cfg.primary_tx_rate      = `TX_RATE_MULT;
			st_nxt.cfg.bitclk_per_frame_sel = `TX_BCLK_FRAME;
			st_nxt.secondary_en = 1'b0;
			st_nxt.dac_mute = (strap.mute_pin && !strap.mute_pin_float) ?
				4'hf : 4'h0;
			st_nxt.powerdown = strap.multifunc_pin_seven;
		end else begin
			st_nxt.route        = i_sw_route;
			st_nxt.tx_src_err   = 1'b0;
			st_nxt.cfg          = i_sw_cfg;
			st_nxt.cfg.word_len = i_sw_cfg.word_len;
			st_nxt.secondary_en = 1'b1;
			st_nxt.dac_mute     = 4'h0;
			if (strap.mute_pin && !strap.mute_pin_float && !i_mute_pin_disable) begin
				st_nxt.dac_mute[i_zero_mute_select] = 1'b1;
			end
			st_nxt.powerdown = i_sw_powerdown;
		end
		// for the first clock after reset, software mode and powered down
		if (!st_r.mode_seen) begin
			st_nxt.powerdown = 1'b1;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			st_r <= '0;
			st_r.powerdown <= 1'b1;
			st_r.cfg.primary_tx_rate <= `TX_RATE_MULT;
			st_r.cfg.bitclk_per_frame_sel <= `TX_BCLK_FRAME;
			st_r.cfg.word_len <= `WLEN_24;
			zero_r      <= 1'b0;
			unlock_r    <= 1'b1;
			non_audio_r <= 1'b0;
		end else begin
			st_r        <= st_nxt;
			zero_r      <= i_all_dac_zero_flag;
			unlock_r    <= i_rx_unlock;
			non_audio_r <= i_non_audio_code | i_cs_bit_one;
		end
	end

	assign o_hw_mode       = st_r.hw_mode;
	assign o_route         = st_r.route;
	assign o_rx_cfg        = st_r.cfg;
	assign o_tx_cfg        = st_r.cfg;
	assign o_secondary_en  = st_r.secondary_en;
	assign o_dac_soft_mute = st_r.dac_mute;
	assign o_powerdown     = st_r.powerdown;
	assign o_tx_src_err    = st_r.tx_src_err;

	// status pins swap function with the mode; in software mode the control port owns the serial out pin and the wire mode pin is released
	assign o_wire_mode_pin_o  = st_r.hw_mode ? unlock_r : i_sw_wire_mode_out;
	assign o_wire_mode_pin_oe = st_r.hw_mode;
	assign o_ctrl_serial_out_pin_o  = st_r.hw_mode ? non_audio_r : i_sw_serial_out;
	assign o_ctrl_serial_out_pin_oe = st_r.hw_mode | i_sw_serial_out_oe;

	// the float detector is the only cue that nobody drives the pin
	assign o_mute_pin_o  = zero_r;
	assign o_mute_pin_oe = strap.mute_pin_float;

	assign o_multifunc_pin_seven_o = i_gp_output_seven_sel ? i_gp_output_seven :
		i_secondary_frame_clock;
	assign o_multifunc_pin_seven_oe = !st_r.hw_mode &&
		(i_gp_output_seven_sel || i_secondary_frame_clock_oe);
endmodule

// ==== dv/hw_mode_pin_config_assertions.sv ====
`timescale 1ns/10ps
module hw_mode_pin_config_assertions (
	input wire logic			I_CORE_CLK,
	input wire logic			I_NRST,
	input wire logic			i_control_mode_pin,
	input wire logic			i_route_pin_one,
	input wire logic			i_route_pin_three,
	input wire logic			i_route_pin_four,
	input wire logic			i_ctrl_select_pin,
	input wire logic			i_ctrl_sclk_pin,
	input wire logic			i_mute_pin,
	input wire logic			i_mute_pin_float,
	input wire logic			i_multifunc_pin_seven,
	input wire logic			i_rx_unlock,
	input wire logic			i_all_dac_zero_flag,
	input wire logic			o_hw_mode,
	input wire control_mode_pin_pkg::route_type	o_route,
	input wire control_mode_pin_pkg::port_cfg_type	o_tx_cfg,
	input wire logic [3:0]			o_dac_soft_mute,
	input wire logic			o_powerdown,
	input wire logic			o_wire_mode_pin_o,
	input wire logic			o_mute_pin_o,
	input wire logic			o_mute_pin_oe
);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_NRST);
	// eight stable cycles cover the synchroniser plus the state register
	a_dac_route: assert property ((i_control_mode_pin && $stable(i_route_pin_one))[*8] |->
		o_route.dac_source_sel == i_route_pin_one) else $error("dac source differs from pin");
	a_tx_route: assert property ((i_control_mode_pin && !(i_route_pin_four && !i_route_pin_three)
		&& $stable({i_route_pin_four, i_route_pin_three}))[*8]
		|-> o_route.spdif_tx_source_sel == {i_route_pin_four, i_route_pin_three})
		else $error("spdif source differs from pins");
	a_tx_refuse: assert property (o_route.spdif_tx_source_sel != 2'h2)
		else $error("unsupported spdif source taken");
	a_fmt_pins: assert property ((i_control_mode_pin
		&& $stable({i_ctrl_select_pin, i_ctrl_sclk_pin}))[*8]
		|-> o_tx_cfg.fmt == {i_ctrl_select_pin, i_ctrl_sclk_pin}
		&& o_tx_cfg.word_len == ((o_tx_cfg.fmt == 2'h1) ? 6'h14 : 6'h18))
		else $error("format or length differs from pins");
	a_unlock_pin: assert property (o_hw_mode && $past(o_hw_mode) |->
		o_wire_mode_pin_o == $past(i_rx_unlock)) else $error("unlock pin wrong");
	a_mute_all: assert property ((i_control_mode_pin && !i_mute_pin_float
		&& $stable(i_mute_pin))[*8] |-> o_dac_soft_mute == {4{i_mute_pin}})
		else $error("dac mute differs from pin");
	a_zero_out: assert property (i_mute_pin_float[*8] |-> o_mute_pin_oe
		&& o_dac_soft_mute == 4'h0 && o_mute_pin_o == $past(i_all_dac_zero_flag))
		else $error("zero flag not on mute pin");
	a_pin7_pd: assert property ((i_control_mode_pin && $stable(i_multifunc_pin_seven))[*8]
		|-> o_powerdown == i_multifunc_pin_seven) else $error("powerdown differs from pin");
endmodule

bind hw_mode_pin_config hw_mode_pin_config_assertions i_hw_mode_pin_config_assertions (.*);

// ==== dv/strap_model.sv ====
`timescale 1ns/10ps
module strap_model (
	input  wire logic			i_clk,
	input  wire control_mode_pin_pkg::strap_type	i_set,
	output control_mode_pin_pkg::strap_type		o_pins
);
	logic	t = 1'b0;
	// a floating pin toggles on every falling clock edge, never holding its last driven level
	always @(negedge i_clk) t <= ~t;
	always_comb begin
		o_pins = i_set;
		if (i_set.mute_pin_float) o_pins.mute_pin = t;
	end
endmodule

// ==== dv/hw_mode_pin_config_tb.sv ====
`timescale 1ns/10ps
module hw_mode_pin_config_tb;
	logic				I_CORE_CLK = '0, I_NRST = '0, i_control_mode_pin = '1;
	control_mode_pin_pkg::strap_type		s = '0, p;
	control_mode_pin_pkg::route_type		i_sw_route = '0, o_route;
	control_mode_pin_pkg::port_cfg_type	i_sw_cfg = '0, o_rx_cfg, o_tx_cfg;
	logic [1:0]			i_zero_mute_select = '0;
	logic [3:0]			o_dac_soft_mute;
	logic				i_mute_pin_disable = '0, i_sw_powerdown = '0, i_sw_wire_mode_out = '0,
					i_sw_serial_out = '0, i_sw_serial_out_oe = '0, i_gp_output_seven = '0,
					i_secondary_frame_clock = '0, i_secondary_frame_clock_oe = '0,
					i_gp_output_seven_sel = '0, i_rx_unlock = '0, i_non_audio_code = '0,
					i_cs_bit_one = '0, i_all_dac_zero_flag = '0;
	logic				o_hw_mode, o_secondary_en, o_powerdown, o_tx_src_err,
					o_wire_mode_pin_o, o_wire_mode_pin_oe, o_ctrl_serial_out_pin_o,
					o_ctrl_serial_out_pin_oe, o_mute_pin_o, o_mute_pin_oe,
					o_multifunc_pin_seven_o, o_multifunc_pin_seven_oe;
	int				bad_count = 0, check_count = 0, cyc = 0;
	logic [1:0]			c;

	strap_model i_strap_model (.i_clk(I_CORE_CLK), .i_set(s), .o_pins(p));
	hw_mode_pin_config i_hw_mode_pin_config (.*, .i_route_pin_one(p.route_pin_one),
		.i_route_pin_two(p.route_pin_two), .i_route_pin_three(p.route_pin_three),
		.i_route_pin_four(p.route_pin_four), .i_ctrl_select_pin(p.ctrl_select_pin),
		.i_ctrl_sclk_pin(p.ctrl_sclk_pin), .i_ctrl_serial_in_pin(p.ctrl_serial_in_pin),
		.i_mute_pin(p.mute_pin), .i_mute_pin_float(p.mute_pin_float),
		.i_multifunc_pin_seven(p.multifunc_pin_seven));

	always #5 I_CORE_CLK = ~I_CORE_CLK;
	always @(posedge I_CORE_CLK) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			test_done;
		end
	end

	task test_done;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// straps need the synchroniser and state register to settle
	task st; repeat (8) @(negedge I_CORE_CLK); endtask

	task t_route;
		for (int k = 0; k < 4; k++) begin
			c = (k == 2) ? 2'h3 : k[1:0];
			s.route_pin_one = k[0];
			s.route_pin_two = k[1];
			{s.route_pin_four, s.route_pin_three} = c;
			st;
			chk(o_route, {k[0], k[1], c});
		end
		{s.route_pin_four, s.route_pin_three} = 2'h2;
		st;
		chk({o_route.spdif_tx_source_sel, o_tx_src_err}, 3'h7);
	endtask
	task t_fmt;
		for (int k = 0; k < 4; k++) begin
			{s.ctrl_select_pin, s.ctrl_sclk_pin} = k[1:0];
			st;
			chk({o_tx_cfg.fmt, o_tx_cfg.word_len}, {k[1:0], k == 1 ? 6'h14 : 6'h18});
			chk({o_rx_cfg.fmt, o_rx_cfg.word_len}, {k[1:0], k == 1 ? 6'h14 : 6'h18});
		end
	endtask
	task t_master;
		for (int k = 0; k < 2; k++) begin
			s.ctrl_serial_in_pin = k[0];
			st;
			chk({o_tx_cfg.tx_master, o_tx_cfg.primary_tx_rate, o_tx_cfg.bitclk_per_frame_sel},
				{k[0], 10'h100, 8'h40});
		end
	endtask
	task t_status;
		for (int k = 0; k < 8; k++) begin
			{i_rx_unlock, i_non_audio_code, i_cs_bit_one} = k[2:0];
			@(negedge I_CORE_CLK);
			chk({o_wire_mode_pin_o, o_wire_mode_pin_oe}, {k[2], 1'b1});
			chk({o_ctrl_serial_out_pin_o, o_ctrl_serial_out_pin_oe}, {k[1] | k[0], 1'b1});
		end
	endtask
	task t_mute;
		for (int k = 1; k >= 0; k--) begin
			s.mute_pin = k[0];
			s.multifunc_pin_seven = k[0];
			st;
			chk({o_dac_soft_mute, o_mute_pin_oe, o_powerdown}, {{4{k[0]}}, 1'b0, k[0]});
			chk(o_multifunc_pin_seven_oe, 1'b0);
		end
		s.mute_pin_float = 1'b1;
		i_all_dac_zero_flag = 1'b1;
		st;
		chk({o_dac_soft_mute, o_mute_pin_oe, o_mute_pin_o}, 6'h03);
		i_all_dac_zero_flag = 1'b0;
		@(negedge I_CORE_CLK);
		chk(o_mute_pin_o, 1'b0);
	endtask
	task t_sw;
		i_control_mode_pin = 1'b0;
		i_sw_route = 4'hb;
		i_zero_mute_select = 2'h2;
		{s.mute_pin_float, s.mute_pin} = 2'h1;
		{i_sw_powerdown, i_gp_output_seven_sel, i_gp_output_seven, i_sw_serial_out, i_sw_serial_out_oe} = '1;
		st;
		chk({o_hw_mode, o_route, o_secondary_en, o_dac_soft_mute}, 10'h174);
		chk({o_powerdown, o_multifunc_pin_seven_o, o_multifunc_pin_seven_oe,
			o_ctrl_serial_out_pin_o}, 4'hf);
		i_mute_pin_disable = 1'b1;
		st;
		chk(o_dac_soft_mute, 4'h0);
		I_NRST = 1'b0;
		@(negedge I_CORE_CLK);
		chk({o_hw_mode, o_powerdown}, 2'h1);
		I_NRST = 1'b1;
		@(negedge I_CORE_CLK);
		chk(o_powerdown, 1'b1);
	endtask

	initial begin
		repeat (4) @(negedge I_CORE_CLK);
		I_NRST = 1'b1;
		st;
		chk({o_hw_mode, o_secondary_en, o_powerdown}, 3'h4);
		t_route;
		t_fmt;
		t_master;
		t_status;
		t_mute;
		t_sw;
		test_done;
	end
endmodule
